/* cowb_consts.svh */
`ifndef COWB_CONSTS_SVH
`define COWB_CONSTS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define COWB_ADDR_OPTIONS    8'h00
`define COWB_ADDR_WARM_BOOT  8'h04
`define COWB_ADDR_IRQ_STATUS 8'h08
`define COWB_ADDR_IRQ_MASK   8'h0C
`define COWB_ADDR_ACTIVITY   8'h10

// ----------------------------------------
// options register fields
// ----------------------------------------
`define COWB_OPT_RELEASE_BIT 17
`define COWB_OPT_ACT_HI      16
`define COWB_OPT_ACT_LO      15
`define COWB_OPT_INITPIN_BIT 9
`define COWB_OPT_SCRUBDIS_BIT 8
`define COWB_OPT_WAIT_HI     3
`define COWB_OPT_WAIT_LO     2
`define COWB_OPT_PAGE_HI     1
`define COWB_OPT_PAGE_LO     0
`define COWB_OPT_WMASK       32'h0003_830F
`define COWB_OPT_RESET       32'h0000_0000

// ----------------------------------------
// warm boot register fields
// ----------------------------------------
`define COWB_WB_SEL_HI       28
`define COWB_WB_SEL_LO       27
`define COWB_WB_DRIVE_BIT    26
`define COWB_WB_ADDR_HI      25
`define COWB_WB_WMASK        32'h1FFF_FFFF
`define COWB_WB_RESET        32'h0000_0000

// ----------------------------------------
// interrupt bits and misc
// ----------------------------------------
`define COWB_IRQ_WIDTH       4
`define COWB_IRQ_SCRUB_ERR   0
`define COWB_IRQ_HALT        1
`define COWB_IRQ_WARM_BOOT   2
`define COWB_IRQ_FALLBACK    3
`define COWB_PAGE_RESERVED   2'h3
`define COWB_RESP_OKAY       2'h0
`define COWB_RESP_SLVERR     2'h2

`endif

/* cowb_pkg.sv */
package cowb_pkg;

    typedef enum logic [1:0]
    {
        COWB_ACT_CONTINUE     = 2'b00,
        COWB_ACT_HALT         = 2'b01,
        COWB_ACT_CORRECT_CONT = 2'b10,
        COWB_ACT_CORRECT_HALT = 2'b11
    } cowb_action_t;

    typedef struct packed
    {
        logic         keep_port_release_on_desynchronize_command_sel;
        cowb_action_t scrub_error_action;
        logic         scrub_error_on_init_pin;
        logic         scrub_disable;
        logic [1:0]   flash_first_read_wait;
        logic [1:0]   flash_page_length;
    } cowb_options_t;

    typedef struct packed
    {
        logic [1:0]  sel_value;
        logic        revision_select_drive_n;
        logic [25:0] start_addr;
    } cowb_warm_boot_t;

    typedef struct packed
    {
        logic [1:0]  sel_out;
        logic        sel_oe;
        logic [25:0] fetch_addr;
        logic        boot_go;
    } cowb_boot_pins_t;

endpackage

/* cowb_scrub_ctl.sv */
`timescale 1ns/1ps
`include "cowb_consts.svh"

module cowb_scrub_ctl
    import cowb_pkg::*;
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         scrub_disable,
    input  wire cowb_action_t scrub_error_action,
    input  wire logic         scrub_error_on_init_pin,
    input  wire logic         scrub_error,
    input  wire logic         resume,
    output logic              scrub_run,
    output logic              correct_req,
    output logic              halted,
    output logic              init_pin_o,
    output logic              init_pin_oe
);

    logic halted_q;
    logic halted_d;
    logic err_seen_q;
    logic correct_q;

    wire  err_now   = scrub_error & ~scrub_disable & ~halted_q;
    wire  act_halt  = (scrub_error_action == COWB_ACT_HALT) | (scrub_error_action == COWB_ACT_CORRECT_HALT);
    wire  act_fix   = (scrub_error_action == COWB_ACT_CORRECT_CONT) | (scrub_error_action == COWB_ACT_CORRECT_HALT);

    // a halting error wins over resume while running; while halted the error is masked and resume clears the halt
    assign halted_d = (err_now & act_halt) | (halted_q & ~resume);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            halted_q   <= 1'b0;
            err_seen_q <= 1'b0;
            correct_q  <= 1'b0;
        end
        else
        begin
            halted_q   <= halted_d;
            correct_q  <= err_now & act_fix;
            err_seen_q <= err_now | (err_seen_q & ~resume);
        end
    end

    assign scrub_run   = ~scrub_disable & ~halted_q;
    assign correct_req = correct_q;
    assign halted      = halted_q;
    // open drain: only ever pulls low, never drives high
    assign init_pin_o  = 1'b0;
    assign init_pin_oe = scrub_error_on_init_pin & err_seen_q;

endmodule // cowb_scrub_ctl

/* cowb_regs.sv */
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "cowb_consts.svh"

// How it works
// - bit 17 of the options register set lets the desynchronize command end port retention, clear keeps it.
// - bits 16:15 pick the scrub error response: continue, halt, correct and continue, correct and halt.
// - bit 9 set makes the open-drain init pin pull low to flag a scrub error; clear leaves it alone.
// - scrubbing runs while bit 8 is zero and the scrubber is not halted, and stops when it is one.
// - bits 3:2 set the first flash read wait to one through four configuration clock cycles.
// - bits 1:0 set flash page length to one, four or eight units; code 3 is reserved and not used.
// - on warm boot the revision-select pins carry warm boot register bits 28:27.
// - bit 26 low leaves the revision-select pins undriven, high drives them.
// - a warm boot fetches the next image from the 26-bit address in bits 25:0.
// - a fallback boot drives the revision-select pins to zero regardless of the register.

module cowb_regs
    import cowb_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // configuration engine side
    input  wire logic        desynchronize_command,
    input  wire logic        scrub_error,
    input  wire logic        scrub_resume,
    input  wire logic        warm_boot_req,
    input  wire logic        fallback_req,
    input  wire logic        flash_read_start,
    output logic             config_port_retention,
    output logic             scrub_run,
    output logic             scrub_correct_req,
    output logic             scrub_halted,
    output logic             init_pin_o,
    output logic             init_pin_oe,
    output logic             flash_first_read_done,
    output logic [3:0]       flash_page_units,
    output logic [1:0]       revision_select_pins_o,
    output logic             revision_select_pins_oe,
    output logic [25:0]      boot_fetch_addr,
    output logic             boot_fetch_go,
    output logic             irq
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [31:0]                opt_q;
    logic [31:0]                wb_q;
    logic [`COWB_IRQ_WIDTH-1:0] sts_q;
    logic [`COWB_IRQ_WIDTH-1:0] mask_q;
    logic                       retain_q;
    cowb_boot_pins_t            pins_q;
    logic [2:0]                 wait_cnt_q;
    logic                       wait_busy_q;
    logic                       wait_done_q;
    logic                       irq_q;
    logic                       halted_prev_q;

    cowb_options_t   opt;
    cowb_warm_boot_t wb;

    assign opt = {opt_q[`COWB_OPT_RELEASE_BIT], opt_q[`COWB_OPT_ACT_HI:`COWB_OPT_ACT_LO],
                  opt_q[`COWB_OPT_INITPIN_BIT], opt_q[`COWB_OPT_SCRUBDIS_BIT],
                  opt_q[`COWB_OPT_WAIT_HI:`COWB_OPT_WAIT_LO], opt_q[`COWB_OPT_PAGE_HI:`COWB_OPT_PAGE_LO]};
    assign wb  = wb_q[`COWB_WB_SEL_HI:0];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb, input logic [31:0] wmask);
        logic [31:0] be;
        be = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
        merge = (old & ~be) | (nw & be);
    endfunction

    // ----------------------------------------
    // write channel
    // ----------------------------------------
    logic       aw_held_q;
    logic [7:0] aw_addr_q;
    logic       w_held_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take  = s_axi_wvalid & s_axi_wready;
    wire wr_go   = aw_held_q & w_held_q & ~s_axi_bvalid;
    wire hit_opt = wr_go & (aw_addr_q == `COWB_ADDR_OPTIONS);
    wire hit_wb  = wr_go & (aw_addr_q == `COWB_ADDR_WARM_BOOT);
    wire hit_msk = wr_go & (aw_addr_q == `COWB_ADDR_IRQ_MASK);
    wire wr_ok   = hit_opt | hit_wb | hit_msk | (aw_addr_q == `COWB_ADDR_IRQ_STATUS) |
                   (aw_addr_q == `COWB_ADDR_ACTIVITY);

    // reserved page code keeps the previous length
    wire [31:0] opt_new  = merge(opt_q, w_data_q, w_strb_q, `COWB_OPT_WMASK);
    wire        page_bad = opt_new[`COWB_OPT_PAGE_HI:`COWB_OPT_PAGE_LO] == `COWB_PAGE_RESERVED;
    wire [31:0] opt_d    = page_bad ? {opt_new[31:`COWB_OPT_PAGE_HI+1], opt_q[`COWB_OPT_PAGE_HI:0]}
                                    : opt_new;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            aw_addr_q    <= 8'h00;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `COWB_RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (w_take)
            begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `COWB_RESP_OKAY : `COWB_RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    assign s_axi_awready = ~aw_held_q;
    assign s_axi_wready  = ~w_held_q;

    // ----------------------------------------
    // read channel
    // ----------------------------------------
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire [7:0] ar_a = {s_axi_araddr[7:2], 2'b00};
    wire rd_sts  = ar_take & (ar_a == `COWB_ADDR_IRQ_STATUS);
    wire [31:0] activity = {27'h0, retain_q, scrub_halted, scrub_run, pins_q.sel_oe, wait_busy_q};
    wire [31:0] rd_mux =
        (ar_a == `COWB_ADDR_OPTIONS)    ? opt_q :
        (ar_a == `COWB_ADDR_WARM_BOOT)  ? wb_q :
        (ar_a == `COWB_ADDR_IRQ_STATUS) ? {28'h0, sts_q} :
        (ar_a == `COWB_ADDR_IRQ_MASK)   ? {28'h0, mask_q} :
        (ar_a == `COWB_ADDR_ACTIVITY)   ? activity : 32'h0000_0000;
    wire rd_ok = (ar_a == `COWB_ADDR_OPTIONS) | (ar_a == `COWB_ADDR_WARM_BOOT) |
                 (ar_a == `COWB_ADDR_IRQ_STATUS) | (ar_a == `COWB_ADDR_IRQ_MASK) |
                 (ar_a == `COWB_ADDR_ACTIVITY);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `COWB_RESP_OKAY;
        end
        else if (ar_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_ok ? `COWB_RESP_OKAY : `COWB_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    assign s_axi_arready = ~s_axi_rvalid;

    // ----------------------------------------
    // option registers
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            opt_q  <= `COWB_OPT_RESET;
            wb_q   <= `COWB_WB_RESET;
            mask_q <= '0;
        end
        else
        begin
            if (hit_opt)
                opt_q <= opt_d;
            if (hit_wb)
                wb_q <= merge(wb_q, w_data_q, w_strb_q, `COWB_WB_WMASK);
            if (hit_msk)
                mask_q <= w_data_q[`COWB_IRQ_WIDTH-1:0] & {`COWB_IRQ_WIDTH{w_strb_q[0]}};
        end
    end

    // ----------------------------------------
    // port retention
    // ----------------------------------------
    // retention is set only by reset; the desynchronize command clears it when option bit 17 is set
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            retain_q <= 1'b1;
        else if (desynchronize_command & opt.keep_port_release_on_desynchronize_command_sel)
            retain_q <= 1'b0;
    end

    // ----------------------------------------
    // scrubber
    // ----------------------------------------
    logic scrub_run_w;
    logic correct_w;
    logic halted_w;
    logic init_o_w;
    logic init_oe_w;

    cowb_scrub_ctl u_scrub
    (
        .aclk                    (aclk),
        .aresetn                 (aresetn),
        .scrub_disable           (opt.scrub_disable),
        .scrub_error_action      (opt.scrub_error_action),
        .scrub_error_on_init_pin (opt.scrub_error_on_init_pin),
        .scrub_error             (scrub_error),
        .resume                  (scrub_resume),
        .scrub_run               (scrub_run_w),
        .correct_req             (correct_w),
        .halted                  (halted_w),
        .init_pin_o              (init_o_w),
        .init_pin_oe             (init_oe_w)
    );

    // ----------------------------------------
    // flash first read wait and page length
    // ----------------------------------------
    wire [2:0] wait_len = {1'b0, opt.flash_first_read_wait} + 3'd1;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wait_cnt_q  <= 3'd0;
            wait_busy_q <= 1'b0;
            wait_done_q <= 1'b0;
        end
        else
        begin
            wait_done_q <= 1'b0;
            if (flash_read_start & ~wait_busy_q)
            begin
                wait_busy_q <= 1'b1;
                wait_cnt_q  <= wait_len - 3'd1;
                wait_done_q <= (wait_len == 3'd1);
                if (wait_len == 3'd1)
                    wait_busy_q <= 1'b0;
            end
            else if (wait_busy_q)
            begin
                wait_cnt_q <= wait_cnt_q - 3'd1;
                if (wait_cnt_q == 3'd1)
                begin
                    wait_busy_q <= 1'b0;
                    wait_done_q <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // warm boot pins and fetch
    // ----------------------------------------
    wire halt_rise = halted_w & ~halted_prev_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pins_q        <= '0;
            sts_q         <= '0;
            irq_q         <= 1'b0;
            halted_prev_q <= 1'b0;
        end
        else
        begin
            halted_prev_q  <= halted_w;
            pins_q.boot_go <= warm_boot_req | fallback_req;
            if (fallback_req)
            begin
                pins_q.sel_out    <= 2'b00;
                pins_q.sel_oe     <= 1'b1;
                pins_q.fetch_addr <= 26'h000_0000;
            end
            else if (warm_boot_req)
            begin
                pins_q.sel_out    <= wb.sel_value;
                pins_q.sel_oe     <= wb.revision_select_drive_n;
                pins_q.fetch_addr <= wb.start_addr;
            end
            // set wins over the clear-on-read
            sts_q <= (sts_q & ~{`COWB_IRQ_WIDTH{rd_sts}}) |
                     {fallback_req, warm_boot_req & ~fallback_req, halt_rise,
                      scrub_error & scrub_run_w};
            irq_q <= |(sts_q & mask_q);
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            config_port_retention   <= 1'b1;
            scrub_run               <= 1'b0;
            scrub_correct_req       <= 1'b0;
            scrub_halted            <= 1'b0;
            init_pin_o              <= 1'b0;
            init_pin_oe             <= 1'b0;
            flash_page_units        <= 4'd1;
            revision_select_pins_o  <= 2'b00;
            revision_select_pins_oe <= 1'b0;
            boot_fetch_addr         <= 26'h000_0000;
            boot_fetch_go           <= 1'b0;
        end
        else
        begin
            config_port_retention   <= retain_q;
            scrub_run               <= scrub_run_w;
            scrub_correct_req       <= correct_w;
            scrub_halted            <= halted_w;
            init_pin_o              <= init_o_w;
            init_pin_oe             <= init_oe_w;
            flash_page_units        <= (opt.flash_page_length == 2'b01) ? 4'd4 :
                                       (opt.flash_page_length == 2'b10) ? 4'd8 : 4'd1;
            revision_select_pins_o  <= pins_q.sel_out;
            revision_select_pins_oe <= pins_q.sel_oe;
            boot_fetch_addr         <= pins_q.fetch_addr;
            boot_fetch_go           <= pins_q.boot_go;
        end
    end

    assign flash_first_read_done = wait_done_q;
    assign irq                   = irq_q;

endmodule // cowb_regs

/* cowb_regs_assertions.sv */
`timescale 1ns/1ps

// ----
// port checker
// ----
module cowb_regs_assertions (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        desynchronize_command,
    input wire logic        scrub_error,
    input wire logic        warm_boot_req,
    input wire logic        fallback_req,
    input wire logic        flash_read_start,
    input wire logic        config_port_retention,
    input wire logic        scrub_run,
    input wire logic        scrub_halted,
    input wire logic        init_pin_o,
    input wire logic        init_pin_oe,
    input wire logic        flash_first_read_done,
    input wire logic [3:0]  flash_page_units,
    input wire logic [1:0]  revision_select_pins_o,
    input wire logic        revision_select_pins_oe,
    input wire logic [25:0] boot_fetch_addr,
    input wire logic        boot_fetch_go
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_retention_drop: assert property (
        $fell(config_port_retention) |-> $past(desynchronize_command) || $past(desynchronize_command, 2))
        else $error("retention dropped with no release command");
    a_halt_stops: assert property (
        scrub_halted |-> !scrub_run)
        else $error("scrub runs while halted");
    a_halt_cause: assert property (
        $rose(scrub_halted) |-> $past(scrub_error) || $past(scrub_error, 2))
        else $error("halt with no scrub error");
    a_init_drain: assert property (
        $rose(init_pin_oe) |-> ($past(scrub_error) || $past(scrub_error, 2)) && init_pin_o == 1'b0)
        else $error("init pin pulled with no error");
    a_wait_bound: assert property (
        flash_read_start |-> ##[1:4] flash_first_read_done)
        else $error("first read wait too long");
    a_done_cause: assert property (
        flash_first_read_done |-> $past(flash_read_start) || $past(flash_read_start, 2)
            || $past(flash_read_start, 3) || $past(flash_read_start, 4))
        else $error("first read done with no start");
    a_page_legal: assert property (
        flash_page_units inside {4'h1, 4'h4, 4'h8})
        else $error("illegal page length");
    a_boot_go: assert property (
        (warm_boot_req || fallback_req) |-> ##2 boot_fetch_go)
        else $error("boot fetch not started");
    a_fallback_zero: assert property (
        fallback_req |-> ##2 revision_select_pins_o == 2'b00 && revision_select_pins_oe && boot_fetch_addr == 26'h0)
        else $error("fallback pins not zero");
    a_pins_hold: assert property (
        !$stable({revision_select_pins_o, revision_select_pins_oe}) |-> $past(warm_boot_req, 2) || $past(fallback_req, 2))
        else $error("pins changed with no boot");
endmodule // cowb_regs_assertions

bind cowb_regs cowb_regs_assertions cowb_regs_assertions_i (
    .aclk(aclk), .aresetn(aresetn), .desynchronize_command(desynchronize_command), .scrub_error(scrub_error),
    .warm_boot_req(warm_boot_req), .fallback_req(fallback_req), .flash_read_start(flash_read_start),
    .config_port_retention(config_port_retention), .scrub_run(scrub_run), .scrub_halted(scrub_halted),
    .init_pin_o(init_pin_o), .init_pin_oe(init_pin_oe), .flash_first_read_done(flash_first_read_done),
    .flash_page_units(flash_page_units), .revision_select_pins_o(revision_select_pins_o),
    .revision_select_pins_oe(revision_select_pins_oe), .boot_fetch_addr(boot_fetch_addr),
    .boot_fetch_go(boot_fetch_go)
);

/* cowb_flash_src.sv */
`timescale 1ns/1ps

// ----
// flash side: starts a first read and times the answer
// ----
module cowb_flash_src (
    input  wire logic  aclk,
    input  wire logic  go,
    input  wire logic  done,
    output logic       read_start,
    output logic [3:0] wait_q
);
    logic on_q = 1'b0;

    // counts edges from the start pulse to the done pulse
    always @(posedge aclk)
    begin
        read_start <= go;
        if (read_start)
        begin
            wait_q <= 4'h0;
            on_q <= 1'b1;
        end
        else if (on_q)
        begin
            wait_q <= wait_q + 4'h1;
            if (done)
                on_q <= 1'b0;
        end
    end
endmodule // cowb_flash_src

/* test_cowb_regs.sv */
`timescale 1ns/1ps

module test_cowb_regs;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  aw_a = 8'h00;
    logic        aw_v = 1'b0;
    logic [31:0] w_d = 32'h0;
    logic        w_v = 1'b0;
    logic        b_r = 1'b0;
    logic [7:0]  ar_a = 8'h00;
    logic        ar_v = 1'b0;
    logic        r_r = 1'b0;
    logic [4:0]  ev = 5'h0;
    logic        rd_go = 1'b0;
    logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, fstart, fdone;
    logic        ret, run, corr, hlt, ipo, ipoe, sel_oe, bgo, irq;
    logic [1:0]  b_resp, r_resp, sel_o;
    logic [31:0] r_d;
    logic [3:0]  units, lat;
    logic [25:0] baddr;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          corr_n = 0;
    int          go_n = 0;

    cowb_regs cowb_regs_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
        .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp),
        .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
        .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
        .desynchronize_command(ev[0]), .scrub_error(ev[1]), .scrub_resume(ev[2]), .warm_boot_req(ev[3]),
        .fallback_req(ev[4]), .flash_read_start(fstart), .config_port_retention(ret), .scrub_run(run),
        .scrub_correct_req(corr), .scrub_halted(hlt), .init_pin_o(ipo), .init_pin_oe(ipoe),
        .flash_first_read_done(fdone), .flash_page_units(units), .revision_select_pins_o(sel_o),
        .revision_select_pins_oe(sel_oe), .boot_fetch_addr(baddr), .boot_fetch_go(bgo), .irq(irq)
    );

    cowb_flash_src cowb_flash_src_i (.aclk(aclk), .go(rd_go), .done(fdone), .read_start(fstart), .wait_q(lat));

    initial
    begin
        forever #5 aclk = ~aclk;
    end

    always @(posedge aclk)
    begin
        if (corr)
            corr_n++;
        if (bgo)
            go_n++;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        aw_a <= a;
        aw_v <= 1'b1;
        w_d <= d;
        w_v <= 1'b1;
        b_r <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            aw_ok = aw_ok | aw_rdy;
            w_ok = w_ok | w_rdy;
            if (aw_ok)
                aw_v <= 1'b0;
            if (w_ok)
                w_v <= 1'b0;
        end
        do @(posedge aclk); while (!b_v);
        chk(b_resp, 32'h0);
        b_r <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        ar_a <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        do @(posedge aclk); while (!ar_rdy);
        ar_v <= 1'b0;
        do @(posedge aclk); while (!r_v);
        d = r_d;
        resp = r_resp;
        r_r <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk(d, exp);
        chk(r, 32'h0);
    endtask

    // one cycle event pulse, then room for the two cycle lag
    task automatic pulse(input int k);
        ev[k] <= 1'b1;
        @(posedge aclk);
        ev[k] <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    task automatic t_fields();
        logic [31:0] d;
        logic [1:0]  r;
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h04, 32'h0);
        chk({ret, run, sel_oe, units}, 32'h61);
        axi_wr(8'h00, 32'hFFFF_FFFF);
        rd_chk(8'h00, 32'h0003_830C);
        chk(run, 32'h0);
        axi_wr(8'h04, 32'hFFFF_FFFF);
        rd_chk(8'h04, 32'h1FFF_FFFF);
        axi_rd(8'h20, d, r);
        chk(d, 32'h0);
        chk(r, 32'h2);
    endtask

    task automatic t_wait();
        for (int i = 0; i < 4; i++)
        begin
            axi_wr(8'h00, {28'h0, i[1:0], i[1:0]});
            rd_go <= 1'b1;
            @(posedge aclk);
            rd_go <= 1'b0;
            repeat (8) @(posedge aclk);
            chk(lat, i + 1);
            chk(units, i == 0 ? 32'h1 : i == 1 ? 32'h4 : 32'h8);
        end
        rd_chk(8'h00, 32'hE);
    endtask

    task automatic t_scrub();
        int          c;
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(8'h0C, 32'h1);
        for (int a = 0; a < 4; a++)
        begin
            axi_wr(8'h00, {15'h0, a[1:0], 5'h0, 1'b1, 9'h0});
            c = corr_n;
            chk(run, 32'h1);
            pulse(1);
            chk(corr_n - c, a[1]);
            chk({hlt, run}, {a[0], !a[0]});
            chk(ipoe ? ipo : 1'b1, 32'h0);
            chk(irq, 32'h1);
            axi_rd(8'h08, d, r);
            chk(d[1:0], {a[0], 1'b1});
            pulse(2);
            chk({hlt, ipoe, irq}, 32'h0);
        end
        // masked and pin role off: nothing must show
        axi_wr(8'h0C, 32'h0);
        axi_wr(8'h00, 32'h0);
        pulse(1);
        chk({ipoe, irq}, 32'h0);
        axi_rd(8'h08, d, r);
    endtask

    task automatic t_boot();
        int g;
        g = go_n;
        axi_wr(8'h04, 32'h16A5_A5A5);
        pulse(3);
        chk({sel_oe, sel_o}, 32'h6);
        chk(baddr, 32'h2A5_A5A5);
        axi_wr(8'h04, 32'h0800_0123);
        pulse(3);
        chk(sel_oe, 32'h0);
        chk(baddr, 32'h123);
        pulse(4);
        chk({sel_oe, sel_o, baddr}, 32'h1000_0000);
        chk(go_n - g, 32'h3);
        rd_chk(8'h04, 32'h0800_0123);
    endtask

    task automatic t_release();
        axi_wr(8'h00, 32'h0);
        pulse(0);
        chk(ret, 32'h1);
        axi_wr(8'h00, 32'h0002_0000);
        chk(ret, 32'h1);
        pulse(0);
        chk(ret, 32'h0);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_fields();
        t_wait();
        t_scrub();
        t_boot();
        t_release();
        print_verdict();
    end

    // whole run is well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge aclk);
        error_cnt++;
        print_verdict();
    end
endmodule // test_cowb_regs
